// File: src/rplss_top.sv
// Notes on behaviour
// R1 - each PCS lane reports a 3-bit framing error increment count
// R2 - a lane's count is meaningful only while its valid qualifier is high
// R3 - consumers add the count only on cycles where its valid is high
// R4 - lane-found bit rises once that PCS lane's marker is seen and demuxed
// R5 - each PCS lane reports its carrying physical lane, valid while synced
// R6 - synced bit needs word boundary lock plus a received lane marker
// R7 - sync error on lock loss from bad headers or no marker received
// R8 - spacing error while markers arrive off the configured spacing, held until fixed
// R9 - consecutive error after four marker errors in a row, held until cleared
// R10 - word error pulses one cycle per malformed marker, back to back allowed
// R11 - expected marker values change only while reset is held
// R12 - a force-resync pulse of one cycle or more restarts sync and alignment
// R13 - all status outputs are registered and zero during reset
// R14 - sync error clears synced and found; they return only after new markers
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "rplss_regs.svh"
module rplss_top
    import rplss_pkg::*;
(
    input  wire logic         CORE_CLK,
    input  wire logic         RST_B,
    input  wire rplss_blk_t   RX_BLK [4],
    input  wire logic [63:0]  EXPECTED_LANE_MARKER_VALUE [4],
    input  wire logic [15:0]  MARKER_SPACING_WORDS,
    input  wire logic         FORCE_RESYNC,
    input  wire logic [3:0]   REG_ADDR,
    input  wire logic [31:0]  REG_WDATA,
    input  wire logic         REG_WR,
    input  wire logic         REG_RD,
    output logic [31:0]       REG_RDATA,
    output logic              IRQ,
    output logic [2:0]        FRAMING_ERR_COUNT [4],
    output logic [3:0]        FRAMING_ERR_VALID,
    output logic [3:0]        LANE_MARKER_FOUND_VECTOR,
    output logic [1:0]        PCS_TO_PHYSICAL_LANE_MAP [4],
    output logic [3:0]        SYNCED_VECTOR,
    output logic [3:0]        SYNC_ERROR_VECTOR,
    output logic [3:0]        MARKER_SPACING_ERROR_VECTOR,
    output logic [3:0]        MARKER_CONSECUTIVE_ERROR_VECTOR,
    output logic [3:0]        MARKER_WORD_ERROR_PULSE
);
    ////////////////////////////////////////////////////////////////////////////////
    // physical lanes
    rplss_lstat_t lane_st [4];
    logic         resync_reg;

    for (genvar p = 0; p < `RPLSS_NLANES; p++) begin : g_lane
        rplss_lane u_lane (
            .clk        (CORE_CLK),
            .rst_b      (RST_B),
            .resync     (resync_reg),
            .blk        (RX_BLK[p]),
            .marker_val (EXPECTED_LANE_MARKER_VALUE),
            .spacing    (MARKER_SPACING_WORDS),
            .stat       (lane_st[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PCS lane k is found on the physical lane that recognised marker k
    function automatic logic [2:0] find_phys(input int k, input rplss_lstat_t s [4]);
        logic [2:0] r;
        r = 3'h0;
        for (int p = 0; p < `RPLSS_NLANES; p++) begin
            if (s[p].found && s[p].pcs_id == 2'(k)) r = {1'b1, 2'(p)};
        end
        return r;
    endfunction : find_phys

    logic [2:0]   hit [4];
    logic [3:0]   found_next;
    logic [3:0]   synced_next;
    logic [3:0]   sync_err_next;
    logic [3:0]   len_err_next;
    logic [3:0]   rep_err_next;
    logic [3:0]   word_err_next;
    logic [3:0]   fe_valid_next;
    logic [2:0]   fe_cnt_next [4];
    logic [1:0]   last_phys_reg [4];

    always_comb begin
        for (int k = 0; k < `RPLSS_NLANES; k++) begin
            hit[k]            = find_phys(k, lane_st);
            found_next[k]     = hit[k][2];
            synced_next[k]    = hit[k][2] & lane_st[hit[k][1:0]].lock; // R6
            // an unmapped PCS lane watches its last physical lane, so a lock loss stays visible
            sync_err_next[k]  = hit[k][2] ? lane_st[hit[k][1:0]].sync_err : lane_st[last_phys_reg[k]].sync_err; // R7
            len_err_next[k]   = hit[k][2] & lane_st[hit[k][1:0]].len_err;
            rep_err_next[k]   = hit[k][2] & lane_st[hit[k][1:0]].rep_err;
            word_err_next[k]  = hit[k][2] & lane_st[hit[k][1:0]].word_err;
            fe_valid_next[k]  = hit[k][2] & lane_st[hit[k][1:0]].fe_valid; // R2
            fe_cnt_next[k]    = fe_valid_next[k] ? lane_st[hit[k][1:0]].fe_cnt : 3'h0;
        end
    end

    // before any mapping a PCS lane watches the physical lane at its own index
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int k = 0; k < `RPLSS_NLANES; k++) last_phys_reg[k] <= 2'(k);
        end else begin
            for (int k = 0; k < `RPLSS_NLANES; k++) begin
                if (hit[k][2]) last_phys_reg[k] <= hit[k][1:0]; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status outputs, one register stage after the lanes
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin // R13
            LANE_MARKER_FOUND_VECTOR        <= 4'h0;
            SYNCED_VECTOR                   <= 4'h0;
            SYNC_ERROR_VECTOR               <= 4'h0;
            MARKER_SPACING_ERROR_VECTOR     <= 4'h0;
            MARKER_CONSECUTIVE_ERROR_VECTOR <= 4'h0;
            MARKER_WORD_ERROR_PULSE         <= 4'h0;
        end else begin
            LANE_MARKER_FOUND_VECTOR        <= found_next; // R4
            SYNCED_VECTOR                   <= synced_next; // R6
            SYNC_ERROR_VECTOR               <= sync_err_next; // R7
            MARKER_SPACING_ERROR_VECTOR     <= len_err_next; // R8
            MARKER_CONSECUTIVE_ERROR_VECTOR <= rep_err_next; // R9
            MARKER_WORD_ERROR_PULSE         <= word_err_next; // R10
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin // R13
            FRAMING_ERR_VALID <= 4'h0;
            for (int k = 0; k < `RPLSS_NLANES; k++) begin
                FRAMING_ERR_COUNT[k]        <= 3'h0;
                PCS_TO_PHYSICAL_LANE_MAP[k] <= 2'h0;
            end
        end else begin
            FRAMING_ERR_VALID <= fe_valid_next; // R2
            for (int k = 0; k < `RPLSS_NLANES; k++) begin
                FRAMING_ERR_COUNT[k] <= fe_cnt_next[k]; // R1
                // map held at zero when unsynced so a stale lane number never leaks out
                PCS_TO_PHYSICAL_LANE_MAP[k] <= synced_next[k] ? hit[k][1:0] : 2'h0; // R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port
    logic        wr_ctrl, rd_int;
    logic [15:0] int_stat_reg;
    logic [15:0] int_mask_reg;
    logic [15:0] int_event;
    logic [15:0] int_stat_next;

    assign wr_ctrl = REG_WR && REG_ADDR == `RPLSS_OFF_CTRL;
    assign rd_int  = REG_RD && REG_ADDR == `RPLSS_OFF_INT_STAT;

    // the pin and the control bit both restart the lanes; the register adds one cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) resync_reg <= 1'b0;
        else resync_reg <= FORCE_RESYNC | (wr_ctrl & REG_WDATA[`RPLSS_CTRL_RESYNC]); // R12
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) int_mask_reg <= `RPLSS_INT_MASK_RST;
        else if (REG_WR && REG_ADDR == `RPLSS_OFF_INT_MASK) int_mask_reg <= REG_WDATA[15:0];
    end

    // events are rising edges of the level errors plus every word error pulse
    always_comb begin
        int_event = 16'h0000;
        int_event[`RPLSS_INT_SYNC_ERR +: 4] = sync_err_next & ~SYNC_ERROR_VECTOR;
        int_event[`RPLSS_INT_WORD_ERR +: 4] = word_err_next;
        int_event[`RPLSS_INT_LEN_ERR  +: 4] = len_err_next & ~MARKER_SPACING_ERROR_VECTOR;
        int_event[`RPLSS_INT_REP_ERR  +: 4] = rep_err_next & ~MARKER_CONSECUTIVE_ERROR_VECTOR;
        // read clears, but an event in the same cycle survives
        int_stat_next = (rd_int ? 16'h0000 : int_stat_reg) | int_event;
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            int_stat_reg <= 16'h0000;
            IRQ          <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            IRQ          <= |(int_stat_next & int_mask_reg);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) REG_RDATA <= 32'h0000_0000;
        else if (!REG_RD) REG_RDATA <= 32'h0000_0000;
        else begin
            case (REG_ADDR)
                `RPLSS_OFF_CTRL:     REG_RDATA <= 32'h0000_0000;
                `RPLSS_OFF_STATUS:   REG_RDATA <= {12'h000, MARKER_CONSECUTIVE_ERROR_VECTOR,
                                                   MARKER_SPACING_ERROR_VECTOR, SYNC_ERROR_VECTOR,
                                                   LANE_MARKER_FOUND_VECTOR, SYNCED_VECTOR};
                `RPLSS_OFF_INT_STAT: REG_RDATA <= {16'h0000, int_stat_reg};
                `RPLSS_OFF_INT_MASK: REG_RDATA <= {16'h0000, int_mask_reg};
                default:             REG_RDATA <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    for (genvar k = 0; k < `RPLSS_NLANES; k++) begin : g_chk
        a_fe_valid_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R2
            !FRAMING_ERR_VALID[k] |-> FRAMING_ERR_COUNT[k] == 3'h0)
            else $error("framing count nonzero while not valid");
        a_fe_count_source: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R1
            FRAMING_ERR_VALID[k] |-> FRAMING_ERR_COUNT[k] == $past(lane_st[hit[k][1:0]].fe_cnt)
                                     && $past(lane_st[hit[k][1:0]].fe_valid))
            else $error("framing count differs from its lane");
        a_found_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R4
            LANE_MARKER_FOUND_VECTOR[k] == $past(found_next[k]))
            else $error("lane found bit not following marker detection");
        a_map_lane_id: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R5
            SYNCED_VECTOR[k] |-> lane_st[PCS_TO_PHYSICAL_LANE_MAP[k]].pcs_id == 2'(k))
            else $error("lane map points at the wrong physical lane");
        a_synced_found: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R6
            SYNCED_VECTOR[k] |-> LANE_MARKER_FOUND_VECTOR[k])
            else $error("synced without a received marker");
        a_err_clears_sync: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R14
            SYNC_ERROR_VECTOR[k] |-> !SYNCED_VECTOR[k])
            else $error("synced while the sync error is high");
    end

    a_resync_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // R12
        FORCE_RESYNC |-> ##3 (LANE_MARKER_FOUND_VECTOR == 4'h0 && SYNCED_VECTOR == 4'h0))
        else $error("force resync did not drop lane status");
    a_reset_zero: assert property (@(posedge CORE_CLK) // R13
        !RST_B |-> (SYNCED_VECTOR == 4'h0 && FRAMING_ERR_VALID == 4'h0 && IRQ == 1'b0))
        else $error("status outputs not zero during reset");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        IRQ == |($past(int_stat_next) & $past(int_mask_reg)))
        else $error("interrupt level does not follow masked status");

    c_all_synced: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
        SYNCED_VECTOR == 4'hf);
    c_word_err_b2b: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
        MARKER_WORD_ERROR_PULSE[0] ##1 MARKER_WORD_ERROR_PULSE[0]);
    c_repeat_err: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
        $rose(MARKER_CONSECUTIVE_ERROR_VECTOR[0]));
    c_resync_after_sync: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
        SYNCED_VECTOR[0] && resync_reg);
endmodule : rplss_top

// File: src/rplss_regs.svh
`ifndef RPLSS_REGS_SVH
`define RPLSS_REGS_SVH
// lane count and block header codes
`define RPLSS_NLANES        4
`define RPLSS_HDR_CTRL      2'b10
// lock, framing and marker error thresholds, counted in received blocks, bad headers and markers
`define RPLSS_LOCK_GOOD     7'd64
`define RPLSS_BAD_WINDOW    7'd63
`define RPLSS_BAD_LIMIT     5'd16
`define RPLSS_FE_WINDOW     3'd7
`define RPLSS_MF_REPEAT     3'd4
// register byte offsets
`define RPLSS_OFF_CTRL      4'h0
`define RPLSS_OFF_STATUS    4'h4
`define RPLSS_OFF_INT_STAT  4'h8
`define RPLSS_OFF_INT_MASK  4'hc
// field positions
`define RPLSS_CTRL_RESYNC   0
`define RPLSS_ST_SYNCED     0
`define RPLSS_ST_FOUND      4
`define RPLSS_ST_SYNC_ERR   8
`define RPLSS_ST_LEN_ERR    12
`define RPLSS_ST_REP_ERR    16
`define RPLSS_INT_SYNC_ERR  0
`define RPLSS_INT_WORD_ERR  4
`define RPLSS_INT_LEN_ERR   8
`define RPLSS_INT_REP_ERR   12
// reset values
`define RPLSS_INT_MASK_RST  16'h0000
`endif

// File: src/rplss_pkg.sv
package rplss_pkg;
    typedef struct packed {
        logic        valid;
        logic [1:0]  hdr;
        logic [63:0] data;
    } rplss_blk_t;

    typedef struct packed {
        logic       lock;
        logic       found;
        logic [1:0] pcs_id;
        logic       sync_err;
        logic       len_err;
        logic       rep_err;
        logic       word_err;
        logic       fe_valid;
        logic [2:0] fe_cnt;
    } rplss_lstat_t;

    typedef enum logic [2:0] {
        ST_HUNT = 3'b001,
        ST_LOCK = 3'b010,
        ST_LOST = 3'b100
    } rplss_lock_t;
endpackage : rplss_pkg

// File: src/rplss_lane.sv
`timescale 1ns/1ps
`include "rplss_regs.svh"
module rplss_lane
    import rplss_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         resync,
    input  wire rplss_blk_t   blk,
    input  wire logic [63:0]  marker_val [4],
    input  wire logic [15:0]  spacing,
    output rplss_lstat_t      stat
);
    rplss_lock_t state_reg;
    logic [6:0]  good_cnt_reg;
    logic [6:0]  win_cnt_reg;
    logic [4:0]  bad_cnt_reg;
    logic [15:0] gap_cnt_reg;
    logic [2:0]  mf_cnt_reg;
    logic [2:0]  fe_acc_reg;
    logic [2:0]  fe_blk_reg;
    logic [2:0]  fe_cnt_reg;
    logic        fe_valid_reg;
    logic        found_reg;
    logic [1:0]  pcs_id_reg;
    logic        sync_err_reg;
    logic        len_err_reg;
    logic        rep_err_reg;
    logic        word_err_reg;

    function automatic logic [2:0] match_marker(input logic [63:0] d, input logic [63:0] m [4]);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < `RPLSS_NLANES; i++) begin
            if (d == m[i]) r = {1'b1, 2'(i)};
        end
        return r;
    endfunction : match_marker

    logic       locked, hdr_bad, mk_hit, at_slot, slot_ok, slot_bad, off_slot, lose, no_marker;
    logic [2:0] mk;
    assign locked    = (state_reg == ST_LOCK);
    assign hdr_bad   = blk.valid & (blk.hdr[0] ~^ blk.hdr[1]);
    assign mk        = match_marker(blk.data, marker_val);
    assign mk_hit    = locked & blk.valid & (blk.hdr == `RPLSS_HDR_CTRL) & mk[2];
    assign at_slot   = found_reg & (gap_cnt_reg == spacing);
    assign slot_ok   = locked & blk.valid & at_slot & mk_hit & (mk[1:0] == pcs_id_reg);
    assign slot_bad  = locked & blk.valid & at_slot & ~slot_ok;
    assign off_slot  = found_reg & mk_hit & ~at_slot;
    // the sixteenth bad header inside one window drops the lock
    assign lose      = locked & hdr_bad & (bad_cnt_reg == `RPLSS_BAD_LIMIT - 5'd1);
    // a full marker period after lock with no marker seen
    assign no_marker = locked & ~found_reg & blk.valid & ~mk_hit & (gap_cnt_reg == spacing);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= ST_HUNT;
            good_cnt_reg <= 7'h00;
            win_cnt_reg  <= 7'h00;
            bad_cnt_reg  <= 5'h00;
        end else if (resync) begin // R12
            state_reg    <= ST_HUNT;
            good_cnt_reg <= 7'h00;
            win_cnt_reg  <= 7'h00;
            bad_cnt_reg  <= 5'h00;
        end else begin
            case (state_reg)
                ST_HUNT, ST_LOST: begin
                    if (hdr_bad) good_cnt_reg <= 7'h00;
                    else if (blk.valid) begin
                        if (good_cnt_reg == `RPLSS_LOCK_GOOD - 7'd1) begin
                            state_reg    <= ST_LOCK;
                            good_cnt_reg <= 7'h00;
                        end else good_cnt_reg <= good_cnt_reg + 7'd1;
                    end
                    win_cnt_reg <= 7'h00;
                    bad_cnt_reg <= 5'h00;
                end
                ST_LOCK: begin
                    if (lose) state_reg <= ST_LOST; // R7
                    else if (blk.valid) begin
                        win_cnt_reg <= (win_cnt_reg == `RPLSS_BAD_WINDOW) ? 7'h00 : win_cnt_reg + 7'd1;
                        if (win_cnt_reg == `RPLSS_BAD_WINDOW) bad_cnt_reg <= 5'h00;
                        else if (hdr_bad) bad_cnt_reg <= bad_cnt_reg + 5'd1;
                    end
                end
                default: state_reg <= ST_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt_reg <= 16'h0000;
            found_reg   <= 1'b0;
            pcs_id_reg  <= 2'h0;
        end else if (resync || !locked || lose) begin // R14
            gap_cnt_reg <= 16'h0000;
            found_reg   <= 1'b0;
        end else if (blk.valid) begin
            gap_cnt_reg <= (mk_hit || gap_cnt_reg == spacing) ? 16'h0000 : gap_cnt_reg + 16'd1;
            if (mk_hit && !found_reg) begin // R4
                found_reg  <= 1'b1;
                pcs_id_reg <= mk[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_err_reg <= 1'b0;
            len_err_reg  <= 1'b0;
            rep_err_reg  <= 1'b0;
            mf_cnt_reg   <= 3'h0;
            word_err_reg <= 1'b0;
        end else if (resync) begin
            sync_err_reg <= 1'b0;
            len_err_reg  <= 1'b0;
            rep_err_reg  <= 1'b0;
            mf_cnt_reg   <= 3'h0;
            word_err_reg <= 1'b0;
        end else begin
            // the error set wins over the clear on a fresh marker
            if (lose || no_marker) sync_err_reg <= 1'b1; // R7
            else if (mk_hit && !found_reg) sync_err_reg <= 1'b0;
            if (off_slot) len_err_reg <= 1'b1; // R8
            else if (slot_ok || !found_reg) len_err_reg <= 1'b0;
            if (slot_bad) begin
                if (mf_cnt_reg != `RPLSS_MF_REPEAT) mf_cnt_reg <= mf_cnt_reg + 3'd1;
                if (mf_cnt_reg >= `RPLSS_MF_REPEAT - 3'd1) rep_err_reg <= 1'b1; // R9
            end else if (slot_ok || !found_reg) begin
                mf_cnt_reg  <= 3'h0;
                rep_err_reg <= 1'b0;
            end
            word_err_reg <= slot_bad; // R10
        end
    end

    // framing error increments: one report per seven locked blocks, so the 3-bit count cannot wrap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fe_acc_reg   <= 3'h0;
            fe_blk_reg   <= 3'h0;
            fe_cnt_reg   <= 3'h0;
            fe_valid_reg <= 1'b0;
        end else begin
            fe_valid_reg <= 1'b0;
            fe_cnt_reg   <= 3'h0;
            if (resync || !locked) begin
                fe_acc_reg <= 3'h0;
                fe_blk_reg <= 3'h0;
            end else if (blk.valid) begin
                if (fe_blk_reg == `RPLSS_FE_WINDOW - 3'd1) begin // R1
                    fe_cnt_reg   <= fe_acc_reg + {2'b00, hdr_bad};
                    fe_valid_reg <= 1'b1;
                    fe_acc_reg   <= 3'h0;
                    fe_blk_reg   <= 3'h0;
                end else begin
                    fe_acc_reg <= fe_acc_reg + {2'b00, hdr_bad};
                    fe_blk_reg <= fe_blk_reg + 3'd1;
                end
            end
        end
    end

    assign stat = '{lock: locked, found: found_reg, pcs_id: pcs_id_reg, sync_err: sync_err_reg,
                    len_err: len_err_reg, rep_err: rep_err_reg, word_err: word_err_reg,
                    fe_valid: fe_valid_reg, fe_cnt: fe_cnt_reg};

    ////////////////////////////////////////////////////////////////////////////////
    a_len_err_set: assert property (@(posedge clk) disable iff (!rst_b) // R8
        off_slot && !resync |=> len_err_reg)
        else $error("marker off its slot did not raise the spacing error");
    a_rep_err_count: assert property (@(posedge clk) disable iff (!rst_b) // R9
        rep_err_reg |-> mf_cnt_reg >= `RPLSS_MF_REPEAT - 3'd1)
        else $error("consecutive marker error raised before four errors");
    a_word_err_pulse: assert property (@(posedge clk) disable iff (!rst_b) // R10
        word_err_reg |-> $past(slot_bad) && !$past(resync))
        else $error("marker word error pulse without a bad marker");
    a_sync_err_lose: assert property (@(posedge clk) disable iff (!rst_b) // R7
        lose && !resync |=> sync_err_reg && !found_reg)
        else $error("lock loss did not raise the sync error");
endmodule : rplss_lane

// File: dv/rplss_rx_model.sv
`timescale 1ns/1ps
module rplss_rx_model
    import rplss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        en,
    input  wire logic [63:0] mk [4],
    input  wire logic [15:0] spacing,
    input  wire logic [3:0]  bad_hdr,
    input  wire logic [3:0]  bad_mk,
    output rplss_blk_t       blk [4]
);
    logic [15:0] cnt_reg;
    // free running so idle data keeps changing; lane p carries pcs lane 3-p to make the map non-trivial
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cnt_reg <= 16'h0000;
        else cnt_reg <= (cnt_reg >= spacing) ? 16'h0000 : cnt_reg + 16'h0001;
    end
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            blk[p].valid = en;
            blk[p].hdr = bad_hdr[p] ? 2'b11 : ((cnt_reg == 16'h0000) ? 2'b10 : 2'b01);
            blk[p].data = (cnt_reg != 16'h0000) ? {4{cnt_reg ^ 16'h5a5a}} : (bad_mk[p] ? ~mk[3-p] : mk[3-p]);
        end
    end
endmodule : rplss_rx_model

// File: dv/rx_pcs_lane_sync_status_tb.sv
`timescale 1ns/1ps
module rx_pcs_lane_sync_status_tb;
    import rplss_pkg::*;
    logic clk = 1'b0, rst_b, frs = 1'b0, wr = 1'b0, rdq = 1'b0, en = 1'b0, irq, sn;
    logic [3:0]  adr = 4'h0, bh = 4'h0, bm = 4'h0, fv, fd, sy, se, sp, rp, we;
    logic [31:0] wd = 32'h0, rd, rdat, s0, s1;
    logic [15:0] fsp = 16'h000f;
    logic [63:0] mk [4] = '{64'h1111_2222_3333_4400, 64'h1111_2222_3333_4411,
                            64'h1111_2222_3333_4422, 64'h1111_2222_3333_4433};
    rplss_blk_t blk [4];
    logic [2:0]  fc [4];
    logic [1:0]  lm [4];
    int fail_count = 0, checks = 0;
    always #12.5 clk = ~clk;
    rplss_rx_model u_far (.clk(clk), .rst_b(rst_b), .en(en), .mk(mk), .spacing(fsp), .bad_hdr(bh),
        .bad_mk(bm), .blk(blk));
    rplss_top u_dut (.CORE_CLK(clk), .RST_B(rst_b), .RX_BLK(blk), .EXPECTED_LANE_MARKER_VALUE(mk),
        .MARKER_SPACING_WORDS(16'h000f), .FORCE_RESYNC(frs), .REG_ADDR(adr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rdq), .REG_RDATA(rdat), .IRQ(irq), .FRAMING_ERR_COUNT(fc),
        .FRAMING_ERR_VALID(fv), .LANE_MARKER_FOUND_VECTOR(fd), .PCS_TO_PHYSICAL_LANE_MAP(lm),
        .SYNCED_VECTOR(sy), .SYNC_ERROR_VECTOR(se), .MARKER_SPACING_ERROR_VECTOR(sp),
        .MARKER_CONSECUTIVE_ERROR_VECTOR(rp), .MARKER_WORD_ERROR_PULSE(we));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] v, input logic [31:0] e);
        checks++;
        if (v !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; adr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [3:0] a);
        @(posedge clk);
        rdq <= 1'b1; adr <= a;
        @(posedge clk);
        rdq <= 1'b0;
        @(posedge clk);
        rd = rdat;
    endtask : rreg
    task wsync();
        for (int n = 0; n < 400 && sy !== 4'hf; n++) @(posedge clk);
        chk(sy, 4'hf);
    endtask : wsync
    ////////////////////////////////////////////////////////////////////////////////
    task t_lock();
        en <= 1'b1;
        wsync();
        chk(fd, 4'hf);
        chk({lm[3], lm[2], lm[1], lm[0]}, 8'h1b);
        chk(se, 4'h0);
    endtask : t_lock
    task t_frame();
        s0 = 0; s1 = 0;
        bh <= 4'h1;
        // lane 3's count is added only while its valid is high; lanes 0 to 2 are summed while any of their valids is high
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (n == 2) bh <= 4'h0;
            if (fv[3] === 1'b1) s0 += fc[3];
            if (fv[2:0] !== 3'h0) s1 += fc[0] + fc[1] + fc[2];
        end
        chk(s0, 3);
        chk(s1, 0);
    endtask : t_frame
    task t_marker();
        s0 = 0; s1 = 0; sn = 1'b0;
        wreg(4'hc, 32'h0000_ffff);
        rreg(4'h8);
        bm <= 4'h2;
        for (int n = 0; n < 104; n++) begin
            @(posedge clk);
            if (n == 63) bm <= 4'h0;
            s0 += we[2];
            s1 |= rp[2];
            sn |= irq;
        end
        chk(s0, 4);
        chk(s1, 1);
        chk(rp[2], 1'b0);
        chk(sn, 1'b1);
        rreg(4'h8);
        chk(rd & 32'h4040, 32'h4040);
        chk(irq, 1'b0);
        rreg(4'h8);
        chk(rd, 0);
        rreg(4'h2);
        chk(rd, 0);
    endtask : t_marker
    task t_space();
        s1 = 0;
        fsp <= 16'h000e;
        for (int n = 0; n < 80; n++) @(posedge clk) s1 |= (sp !== 4'h0);
        fsp <= 16'h000f;
        wsync();
        cyc(40);
        chk(s1, 1);
        chk(sp, 4'h0);
    endtask : t_space
    task t_syncerr();
        s1 = 0;
        bh <= 4'h2;
        for (int n = 0; n < 40; n++) @(posedge clk) s1 |= (se !== 4'h0);
        bh <= 4'h0;
        cyc(2);
        chk(s1, 1);
        chk({sy[2], fd[2]}, 2'b00);
        wsync();
        chk(se, 4'h0);
    endtask : t_syncerr
    task t_resync();
        @(posedge clk);
        frs <= 1'b1;
        cyc(1);
        frs <= 1'b0;
        cyc(5);
        chk({sy, fd}, 8'h00);
        wsync();
        wreg(4'h0, 32'h0000_0001);
        cyc(6);
        chk(sy, 4'h0);
        wsync();
    endtask : t_resync
    ////////////////////////////////////////////////////////////////////////////////
    task finish_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        cyc(20000);
        fail_count++;
        finish_test();
    end
    initial begin
        rst_b <= 1'b0;
        cyc(4);
        chk({irq, fv, fd, sy, se, sp, rp, we}, 29'h0);
        rst_b <= 1'b1;
        t_lock();
        t_frame();
        t_marker();
        t_space();
        t_syncerr();
        t_resync();
        finish_test();
    end
endmodule : rx_pcs_lane_sync_status_tb
